/* cgr_pkg.sv */
// Package with the register map, reset values and carrier types of the clock generator bank.
package cgr_pkg;

   localparam int ADDR_W = 10;

   // Register offsets.
   localparam logic [9:0] ADDR_SPORT_CFG   = 10'h000;
   localparam logic [9:0] ADDR_DEVICE_ID   = 10'h003;
   localparam logic [9:0] ADDR_RDBK_SEL    = 10'h004;
   localparam logic [9:0] ADDR_CUST_LO     = 10'h005;
   localparam logic [9:0] ADDR_CUST_HI     = 10'h006;
   localparam logic [9:0] ADDR_PUMP_CTRL   = 10'h010;
   localparam logic [9:0] ADDR_REF_LO      = 10'h011;
   localparam logic [9:0] ADDR_REF_HI      = 10'h012;
   localparam logic [9:0] ADDR_A_CNT       = 10'h013;
   localparam logic [9:0] ADDR_UPDATE      = 10'h232;

   // Serial port configuration fields; each function has a mirrored pair of bits.
   localparam int SPC_SDO_LO    = 0;
   localparam int SPC_LSB_LO    = 1;
   localparam int SPC_SRST_LO   = 2;
   localparam int SPC_SRST_HI   = 5;
   localparam int SPC_LSB_HI    = 6;
   localparam int SPC_SDO_HI    = 7;
   localparam int RDBK_ACT_BIT  = 0;
   localparam int UPDATE_BIT    = 0;

   localparam logic [7:0] SPORT_CFG_RST = 8'h00;
   localparam logic [7:0] RDBK_SEL_RST  = 8'h00;

   // Buffered/active register set.
   localparam int NSTAGE = 6;
   localparam logic [9:0] STAGE_ADDR [NSTAGE] = '{ADDR_CUST_LO, ADDR_CUST_HI, ADDR_PUMP_CTRL,
                                                  ADDR_REF_LO, ADDR_REF_HI, ADDR_A_CNT};
   localparam logic [7:0] STAGE_RST  [NSTAGE] = '{8'h00, 8'h00, 8'h7d, 8'h01, 8'h00, 8'h00};
   localparam logic [7:0] STAGE_MASK [NSTAGE] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f};
   localparam int ST_CUST_LO = 0;
   localparam int ST_CUST_HI = 1;
   localparam int ST_PUMP    = 2;
   localparam int ST_REF_LO  = 3;
   localparam int ST_REF_HI  = 4;
   localparam int ST_A_CNT   = 5;

   typedef struct packed {
      logic             wr;
      logic             rd;
      logic [9:0]       addr;
      logic [7:0]       wdata;
   } cgr_req_type;

   typedef struct packed {
      logic             valid;
      logic [7:0]       data;
   } cgr_rsp_type;

endpackage

/* cgr_stage_reg.sv */
// One buffered register byte and its active copy.
`timescale 1ns/1ps
module cgr_stage_reg #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WR_MASK   = 8'hff
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       soft_rst,
   input  wire logic       wr_en,
   input  wire logic [7:0] wdata,
   input  wire logic       update,
   output logic      [7:0] buf_q,
   output logic      [7:0] act_q
);
   wire logic [7:0] buf_d = wr_en ? (wdata & WR_MASK) : buf_q;

   always_ff @(posedge clk) begin
      if (!rst_n || soft_rst) begin
         buf_q <= RESET_VAL;
         act_q <= RESET_VAL;
      end else begin
         buf_q <= buf_d;
         // A write in the update cycle lands in the active copy too.
         if (update) begin
            act_q <= buf_d;
         end
      end
   end
endmodule // cgr_stage_reg

/* cgr_bank.sv */
// Configuration register bank of the clock generator with buffered and active copies.
//
// Contract
// - A write to an address outside the map is ignored and changes nothing.
// - A write to an unused location or field changes no stored configuration.
// - Bit 0 of the readback control register makes reads return active rather than buffered values.
// - The reference divider is 14 bits, low byte at one address and bits 13:8 in the next.
// - Writes to staged registers land in the buffer bank and reach the active bank only when the transfer bit is set.
`timescale 1ns/1ps
module cgr_bank
   import cgr_pkg::*;
#(
   parameter logic [7:0] DEVICE_ID = 8'h5a  // Arbitrary identifier value.
) (
   // Clock and reset
   input  wire logic                 I_MCLK,
   input  wire logic                 I_RST_N,
   // Register access from the serial port engine
   input  wire cgr_pkg::cgr_req_type I_REQ,
   output cgr_pkg::cgr_rsp_type      O_RSP,
   // Serial port mode
   output logic                      O_SDO_ACTIVE,
   output logic                      O_LSB_FIRST,
   // Active configuration
   output logic [7:0]                O_PUMP_CTRL,
   output logic [13:0]               O_REF_DIV,
   output logic [5:0]                O_A_CNT,
   output logic [15:0]               O_CUST_VER
);
   import cgr_pkg::*;

   // Refused at elaboration so that the check costs nothing in the built logic.
   if (DEVICE_ID == 8'h00) begin : g_bad_id
      $error("DEVICE_ID must not be zero");
   end

   logic [7:0]  spc_q;
   logic [7:0]  spc_d;
   logic [7:0]  rdbk_q;
   logic        srst_q;
   cgr_rsp_type rsp_q;
   logic [7:0]  buf_v [NSTAGE];
   logic [7:0]  act_v [NSTAGE];
   logic [NSTAGE-1:0] hit;

   wire logic wr       = I_REQ.wr;
   wire logic hit_spc  = (I_REQ.addr == ADDR_SPORT_CFG);
   wire logic hit_rdbk = (I_REQ.addr == ADDR_RDBK_SEL);
   wire logic hit_upd  = (I_REQ.addr == ADDR_UPDATE);
   // Only listed addresses decode; everything else falls through unused.
   wire logic upd      = wr && hit_upd && I_REQ.wdata[UPDATE_BIT];
   wire logic srst_req = wr && hit_spc &&
                         (I_REQ.wdata[SPC_SRST_LO] || I_REQ.wdata[SPC_SRST_HI]);
   wire logic sdo_w    = I_REQ.wdata[SPC_SDO_LO] | I_REQ.wdata[SPC_SDO_HI];
   wire logic lsb_w    = I_REQ.wdata[SPC_LSB_LO] | I_REQ.wdata[SPC_LSB_HI];
   wire logic rd_act   = rdbk_q[RDBK_ACT_BIT];

   // Mirrored pairs are stored as one function each; unused bits stay zero.
   always_comb begin
      spc_d = spc_q;
      if (wr && hit_spc) begin
         spc_d = 8'h00;
         spc_d[SPC_SDO_LO] = sdo_w;
         spc_d[SPC_SDO_HI] = sdo_w;
         spc_d[SPC_LSB_LO] = lsb_w;
         spc_d[SPC_LSB_HI] = lsb_w;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NSTAGE; g++) begin : g_stage
         assign hit[g] = (I_REQ.addr == STAGE_ADDR[g]);
         cgr_stage_reg #(
            .RESET_VAL (STAGE_RST[g]),
            .WR_MASK   (STAGE_MASK[g])
         ) u_reg (
            .clk      (I_MCLK),
            .rst_n    (I_RST_N),
            .soft_rst (srst_q),
            .wr_en    (wr && hit[g] && !srst_q),
            .wdata    (I_REQ.wdata),
            .update   (upd && !srst_q),
            .buf_q    (buf_v[g]),
            .act_q    (act_v[g])
         );
      end
   endgenerate

   // Read mux; unmapped addresses read as zero.
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (hit_spc) begin
         rd_mux = spc_q;
      end else if (I_REQ.addr == ADDR_DEVICE_ID) begin
         rd_mux = DEVICE_ID;
      end else if (hit_rdbk) begin
         rd_mux = rdbk_q;
      end
      for (int i = 0; i < NSTAGE; i++) begin
         if (hit[i]) begin
            rd_mux = rd_act ? act_v[i] : buf_v[i];
         end
      end
   end

   // Soft reset takes one cycle to apply; the stored soft-reset bits never hold a one,
   // so a readback after the write already shows them cleared.
   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N || srst_q) begin
         spc_q  <= SPORT_CFG_RST;
         rdbk_q <= RDBK_SEL_RST;
         srst_q <= 1'b0;
      end else begin
         spc_q  <= spc_d;
         srst_q <= srst_req;
         if (wr && hit_rdbk) begin
            rdbk_q <= {7'h00, I_REQ.wdata[RDBK_ACT_BIT]};
         end
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid <= I_REQ.rd;
         rsp_q.data  <= I_REQ.rd ? rd_mux : 8'h00;
      end
   end

   assign O_RSP        = rsp_q;
   assign O_SDO_ACTIVE = spc_q[SPC_SDO_LO];
   assign O_LSB_FIRST  = spc_q[SPC_LSB_LO];
   assign O_PUMP_CTRL  = act_v[ST_PUMP];
   assign O_REF_DIV    = {act_v[ST_REF_HI][5:0], act_v[ST_REF_LO]};
   assign O_A_CNT      = act_v[ST_A_CNT][5:0];
   assign O_CUST_VER   = {act_v[ST_CUST_HI], act_v[ST_CUST_LO]};
endmodule // cgr_bank

/* cgr_bank_assertions.sv */
// Checker for the configuration register bank.
`timescale 1ns/1ps
module cgr_bank_chk
   import cgr_pkg::*;
#(parameter logic [7:0] DEVICE_ID = 8'h5a) (
   input wire logic I_MCLK,
   input wire logic I_RST_N,
   input wire cgr_pkg::cgr_req_type I_REQ,
   input wire cgr_pkg::cgr_rsp_type O_RSP,
   input wire logic [7:0] O_PUMP_CTRL,
   input wire logic [13:0] O_REF_DIV,
   input wire logic [5:0] O_A_CNT,
   input wire logic [15:0] O_CUST_VER
);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);
   wire upd_w = I_REQ.wr && I_REQ.addr == ADDR_UPDATE && I_REQ.wdata[UPDATE_BIT];
   wire srst_w = I_REQ.wr && I_REQ.addr == ADDR_SPORT_CFG
                 && (I_REQ.wdata[SPC_SRST_LO] || I_REQ.wdata[SPC_SRST_HI]);
   wire rd_w = I_REQ.rd;
   rsp_timing_a: assert property (1'b1 |=> O_RSP.valid == $past(rd_w))
      else $error("read answer timing wrong");
   active_hold_a: assert property (!upd_w && !srst_w && !$past(srst_w) |=>
      $stable({O_PUMP_CTRL, O_REF_DIV, O_A_CNT, O_CUST_VER})) else $error("active changed");
   ref_load_a: assert property (I_REQ.wr && I_REQ.addr == ADDR_REF_LO && !$past(srst_w)
      ##1 upd_w |=> O_REF_DIV[7:0] == $past(I_REQ.wdata, 2)) else $error("divider load");
   cust_load_a: assert property (I_REQ.wr && I_REQ.addr == ADDR_CUST_HI && !$past(srst_w)
      ##1 upd_w |=> O_CUST_VER[15:8] == $past(I_REQ.wdata, 2)) else $error("version load");
   soft_dflt_a: assert property (srst_w |=> ##1 O_PUMP_CTRL == 8'h7d && O_REF_DIV == 14'h0001
      && O_A_CNT == 6'h00 && O_CUST_VER == 16'h0000) else $error("soft reset defaults");
   soft_bits_a: assert property (rd_w && I_REQ.addr == ADDR_SPORT_CFG |=>
      !O_RSP.data[SPC_SRST_LO] && !O_RSP.data[SPC_SRST_HI]) else $error("reset bit stuck");
   ref_mask_a: assert property (rd_w && I_REQ.addr == ADDR_REF_HI |=> O_RSP.data[7:6] == 2'b00)
      else $error("divider high bits");
   id_fixed_a: assert property (rd_w && I_REQ.addr == ADDR_DEVICE_ID |=> O_RSP.data == DEVICE_ID)
      else $error("identifier changed");
   cover property (upd_w);
   cover property (srst_w);
   cover property (rd_w && I_REQ.addr == ADDR_RDBK_SEL);
endmodule // cgr_bank_chk
bind cgr_bank cgr_bank_chk #(.DEVICE_ID(DEVICE_ID)) chk_u (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
   .I_REQ(I_REQ), .O_RSP(O_RSP), .O_PUMP_CTRL(O_PUMP_CTRL), .O_REF_DIV(O_REF_DIV),
   .O_A_CNT(O_A_CNT), .O_CUST_VER(O_CUST_VER));

/* cgr_host.sv */
// Host model issuing one register request at a time.
`timescale 1ns/1ps
module cgr_host
   import cgr_pkg::*;
(
   input  wire logic                 clk,
   input  wire cgr_pkg::cgr_rsp_type rsp,
   output cgr_pkg::cgr_req_type      req
);
   cgr_rsp_type got;
   initial req = '0;
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      req = '{1'b1, 1'b0, a, d};
      @(posedge clk) #1 req = '0;
      @(posedge clk) #1;
   endtask
   task automatic rd(input logic [9:0] a);
      req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk) #1 req = '0;
      got = rsp;
      @(posedge clk) #1;
   endtask
   task automatic update();
      wr(ADDR_UPDATE, 8'h01);
   endtask
endmodule // cgr_host

/* tb_top.sv */
// Bench for the configuration register bank.
`timescale 1ns/1ps
module tb_top;
   import cgr_pkg::*;
   localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier value.
   logic I_MCLK = 1'b0;
   logic I_RST_N = 1'b0;
   cgr_req_type req;
   cgr_rsp_type rsp;
   logic [7:0] pump;
   logic [13:0] refd;
   logic [15:0] cust;
   logic sdo;
   logic lsb;
   logic [5:0] acnt;
   int errors = 0;
   int checks_done = 0;
   cgr_bank #(.DEVICE_ID(ID)) dut_u (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_REQ(req),
      .O_RSP(rsp), .O_SDO_ACTIVE(sdo), .O_LSB_FIRST(lsb), .O_PUMP_CTRL(pump), .O_REF_DIV(refd),
      .O_A_CNT(acnt), .O_CUST_VER(cust));
   cgr_host host_u (.clk(I_MCLK), .rsp(rsp), .req(req));
   initial forever #12.5 I_MCLK = ~I_MCLK;
   task chk(input logic [37:0] seen, input logic [37:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task rchk(input logic [9:0] a, input logic [7:0] exp);
      host_u.rd(a);
      chk(38'(host_u.got), {29'h1, exp});
   endtask
   task conclude();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100us;
      errors++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge I_MCLK);
      #1 I_RST_N = 1'b1;
      chk({pump, refd, cust}, {8'h7d, 14'h0001, 16'h0000});
      host_u.wr(ADDR_DEVICE_ID, 8'hff);
      host_u.wr(10'h007, 8'hff);
      host_u.wr(10'h2ff, 8'hff);
      rchk(ADDR_DEVICE_ID, ID);
      rchk(10'h007, 8'h00);
      host_u.wr(ADDR_SPORT_CFG, 8'h18);
      rchk(ADDR_SPORT_CFG, 8'h00);
      host_u.wr(ADDR_SPORT_CFG, 8'h81);
      rchk(ADDR_SPORT_CFG, 8'h81);
      chk({sdo, lsb}, 38'h2);
      host_u.wr(ADDR_SPORT_CFG, 8'h02);
      rchk(ADDR_SPORT_CFG, 8'h42);
      chk({sdo, lsb}, 38'h1);
      host_u.wr(ADDR_A_CNT, 8'hff);
      host_u.wr(ADDR_REF_LO, 8'h20);
      host_u.wr(ADDR_REF_HI, 8'hff);
      host_u.wr(ADDR_CUST_LO, 8'h34);
      host_u.wr(ADDR_CUST_HI, 8'h12);
      rchk(ADDR_REF_HI, 8'h3f);
      chk(38'(refd), 38'h1);
      host_u.wr(ADDR_RDBK_SEL, 8'hff);
      rchk(ADDR_RDBK_SEL, 8'h01);
      rchk(ADDR_REF_LO, 8'h01);
      host_u.update();
      chk({refd, cust, acnt}, {14'h3f20, 16'h1234, 6'h3f});
      rchk(ADDR_CUST_HI, 8'h12);
      host_u.wr(ADDR_SPORT_CFG, 8'h24);
      @(posedge I_MCLK) #1;
      chk({pump, refd, cust, acnt, sdo, lsb}, {8'h7d, 14'h0001, 16'h0000, 8'h00});
      rchk(ADDR_SPORT_CFG, 8'h00);
      rchk(ADDR_RDBK_SEL, 8'h00);
      conclude();
   end
endmodule // tb_top
